// ==== rtl/smc_pkg.sv ====
// Constants and types shared by the standby mode controller
package smc_pkg;
   // Register addresses (byte offsets on the plain register port)
   localparam logic [7:0] SMC_ADDR_UNLOCK = 8'h0E;
   localparam logic [7:0] SMC_ADDR_SBYCTL = 8'h0F;
   localparam logic [7:0] SMC_ADDR_PRPHCTL = 8'h15;
   localparam logic [7:0] SMC_ADDR_STATUS = 8'h16;
   localparam logic [7:0] SMC_ADDR_PINCFG = 8'h17;
   // Standby control register fields
   localparam int SMC_STOP_BIT = 0;
   localparam int SMC_HALT_BIT = 1;
   localparam int SMC_FLOAT_BIT = 2;
   localparam int SMC_OSCS_BIT = 3;
   localparam int SMC_CLKSEL_BIT = 6;
   // Peripheral control register field
   localparam int SMC_HOLDEN_BIT = 5;
   // Pin configuration register fields
   localparam int SMC_SCLK_SF_BIT = 0;
   localparam int SMC_SER3_SLAVE_BIT = 1;
   localparam int SMC_BUS_SF_BIT = 2;
   // Reset values
   localparam logic [7:0] SMC_SBYCTL_RST = 8'h08;
   localparam logic [7:0] SMC_PRPHCTL_RST = 8'h8C;
   localparam logic [7:0] SMC_PINCFG_RST = 8'h00;
   // Unlock code nibbles
   localparam logic [3:0] SMC_UNLOCK_FIRST = 4'h5;
   localparam logic [3:0] SMC_UNLOCK_SECOND = 4'hA;
   // Pin synchroniser depth
   localparam int SMC_SYNC_STAGES = 3;
   // Peripheral run vector positions
   localparam int SMC_PER_TIMEBASE = 0;
   localparam int SMC_PER_CCT = 1;
   localparam int SMC_PER_TMR = 2;
   localparam int SMC_PER_SER0 = 3;
   localparam int SMC_PER_SER1 = 4;
   localparam int SMC_PER_ADC = 5;
   localparam int SMC_PER_PWM = 6;
   localparam int SMC_PER_WDOG = 7;
   localparam int SMC_PER_SER3 = 8;
   localparam int SMC_PER_RTC = 9;
   localparam int SMC_PER_N = 10;

   typedef enum logic [3:0] {
      SMC_RUN = 4'b0001,
      SMC_HALT = 4'b0010,
      SMC_HOLD = 4'b0100,
      SMC_STOP = 4'b1000
   } smc_state_t;
endpackage

// ==== rtl/smc_sync.sv ====
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module smc_sync
   import smc_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic pin_i,
   output logic level_o
);
   logic [SMC_SYNC_STAGES-1:0] sh_q, sh_d;
   logic level_q, level_d;

   always_comb begin
      sh_d = {sh_q[SMC_SYNC_STAGES-2:0], pin_i};
      level_d = level_q;
      // Stage one feeds only stage two; decision on stages two and three
      if (sh_q[1] == sh_q[2]) begin
         level_d = sh_q[2];
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sh_q <= '0;
         level_q <= 1'b0;
      end else if (ce_i) begin
         sh_q <= sh_d;
         level_q <= level_d;
      end
   end

   assign level_o = level_q;
endmodule

// ==== rtl/smc_unlock.sv ====
// Stop unlock latch armed by a two-byte code sequence
`timescale 1ns/1ps
module smc_unlock
   import smc_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic sys_rst_i,
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   input wire logic clear_i,
   output logic armed_o
);
   logic first_q, first_d;
   logic armed_q, armed_d;

   always_comb begin
      first_d = first_q;
      armed_d = armed_q;
      if (wr_i) begin
         first_d = (wdata_i[3:0] == SMC_UNLOCK_FIRST);
         if (first_q && wdata_i[3:0] == SMC_UNLOCK_SECOND) begin
            armed_d = 1'b1;
         end
      end
      if (clear_i || sys_rst_i) begin
         armed_d = 1'b0;
         first_d = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         first_q <= 1'b0;
         armed_q <= 1'b0;
      end else if (ce_i) begin
         first_q <= first_d;
         armed_q <= armed_d;
      end
   end

   assign armed_o = armed_q;

   // the latch drops the cycle after the stop request, as stop is entered
   a_unlock_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ce_i && clear_i |=> !armed_o)
      else $error("unlock latch not cleared on stop entry");
endmodule

// ==== rtl/smc_top.sv ====
// Standby mode controller: halt, hold and stop sequencing with reset sources
//
// Summary of operation
// - Halt bit stops CPU clock; peripherals keep clock.
// - Hold entered when hold enable set and hold input high.
// - In hold the external bus is released.
// - In hold, bus secondary-function outputs stop driving and float high.
// - Stop bit takes effect only if unlock latch is armed.
// - Stop gates CPU and peripheral clocks.
// - Quick stop keeps main oscillator running.
// - Reset from pin, break, invalid opcode or watchdog overflow.
// - Each standby state has high-speed and low-speed variants.
// - Timers, serial zero/one, converter, PWM stop in stop; watchdog stops in hold.
// - Serial three runs in stop only as slave; real-time counter always.
// - Float stop with clock pin secondary output: serial data pin high impedance.
// - Float stop otherwise: serial data pin keeps serial three data.
// - Float bit floats output pins in stop; clear keeps levels.
// - Codes 5 then A arm unlock latch; stop entry clears it.
// - Halt leaves on interrupt, pin reset or watchdog; halt bit clears.
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module smc_top
   import smc_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic ext_reset_pin_n_i,
   input wire logic hold_pin_i,
   input wire logic break_instruction_i,
   input wire logic opcode_trap_i,
   input wire logic watchdog_overflow_i,
   input wire logic irq_i,
   output logic hold_ack_o,
   output logic cpu_clk_en_o,
   output logic per_clk_en_o,
   output logic [SMC_PER_N-1:0] per_run_o,
   output logic osc_run_o,
   output logic low_speed_o,
   output logic sys_reset_o,
   output logic bus_oe_o,
   output logic port_oe_o,
   input wire logic ser3_data_i,
   output logic p10_sdo_o,
   output logic p10_sdo_oe_o
);
   smc_state_t st_q, st_d;
   logic [7:0] sby_q, sby_d;
   logic [7:0] prph_q, prph_d;
   logic [7:0] pcfg_q, pcfg_d;
   logic [7:0] rdata_q, rdata_d;
   logic hold_lvl, pin_rst;
   logic sys_rst_q, sys_rst_d;
   logic armed, stop_go;
   logic wr_unlock, wr_sby;

   smc_sync u_sync_hold (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .pin_i(hold_pin_i),
      .level_o(hold_lvl)
   );

   smc_sync u_sync_rst (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .pin_i(~ext_reset_pin_n_i),
      .level_o(pin_rst)
   );

   assign wr_unlock = reg_wr_i && reg_addr_i == SMC_ADDR_UNLOCK;
   assign wr_sby = reg_wr_i && reg_addr_i == SMC_ADDR_SBYCTL;
   // stop request accepted only behind the armed latch
   assign stop_go = wr_sby && reg_wdata_i[SMC_STOP_BIT] && armed && st_q == SMC_RUN;

   smc_unlock u_unlock (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .sys_rst_i(sys_rst_q),
      .wr_i(wr_unlock),
      .wdata_i(reg_wdata_i),
      .clear_i(stop_go),
      .armed_o(armed)
   );

   // Reset sources and register file
   always_comb begin
      sys_rst_d = pin_rst || break_instruction_i || opcode_trap_i || watchdog_overflow_i;
      sby_d = sby_q;
      prph_d = prph_q;
      pcfg_d = pcfg_q;
      rdata_d = 8'h00;
      if (reg_wr_i) begin
         case (reg_addr_i)
            SMC_ADDR_SBYCTL: begin
               sby_d = reg_wdata_i;
               // stop bit only sticks when armed
               sby_d[SMC_STOP_BIT] = reg_wdata_i[SMC_STOP_BIT] && stop_go;
            end
            SMC_ADDR_PRPHCTL: prph_d = reg_wdata_i;
            SMC_ADDR_PINCFG: pcfg_d = reg_wdata_i;
            default: ;
         endcase
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            SMC_ADDR_SBYCTL: rdata_d = sby_q;
            SMC_ADDR_PRPHCTL: rdata_d = prph_q;
            SMC_ADDR_PINCFG: rdata_d = pcfg_q;
            SMC_ADDR_STATUS: rdata_d = {3'h0, armed, st_q};
            default: rdata_d = 8'h00;
         endcase
      end
      // leaving halt clears the halt bit
      if (st_q == SMC_HALT && irq_i) begin
         sby_d[SMC_HALT_BIT] = 1'b0;
      end
      // leaving stop clears the stop bit
      if (st_q == SMC_STOP && irq_i) begin
         sby_d[SMC_STOP_BIT] = 1'b0;
      end
      if (sys_rst_q) begin
         sby_d = SMC_SBYCTL_RST;
         prph_d = SMC_PRPHCTL_RST;
         pcfg_d = SMC_PINCFG_RST;
      end
   end

   // Mode sequencer
   always_comb begin
      st_d = st_q;
      case (st_q)
         SMC_RUN: begin
            if (stop_go) begin
               st_d = SMC_STOP;
            // hold needs enable and a high request
            end else if (prph_q[SMC_HOLDEN_BIT] && hold_lvl) begin
               st_d = SMC_HOLD;
            end else if (sby_q[SMC_HALT_BIT]) begin
               st_d = SMC_HALT;
            end
         end
         SMC_HALT: begin
            if (irq_i) begin
               st_d = SMC_RUN;
            end
         end
         SMC_HOLD: begin
            if (!hold_lvl) begin
               st_d = SMC_RUN;
            end
         end
         SMC_STOP: begin
            if (irq_i) begin
               st_d = SMC_RUN;
            end
         end
         default: st_d = SMC_RUN;
      endcase
      // Resets release every mode
      if (sys_rst_q) begin
         st_d = SMC_RUN;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= SMC_RUN;
         sby_q <= SMC_SBYCTL_RST;
         prph_q <= SMC_PRPHCTL_RST;
         pcfg_q <= SMC_PINCFG_RST;
         rdata_q <= 8'h00;
         sys_rst_q <= 1'b0;
      end else if (ce_i) begin
         st_q <= st_d;
         sby_q <= sby_d;
         prph_q <= prph_d;
         pcfg_q <= pcfg_d;
         rdata_q <= rdata_d;
         sys_rst_q <= sys_rst_d;
      end
   end

   assign reg_rdata_o = rdata_q;
   assign sys_reset_o = sys_rst_q;
   // CPU clock off in any standby state
   assign cpu_clk_en_o = st_q == SMC_RUN;
   assign per_clk_en_o = st_q != SMC_STOP;
   // quick stop when oscillator stop bit clear
   assign osc_run_o = !(st_q == SMC_STOP && sby_q[SMC_OSCS_BIT]);
   // clock select carries the speed variant into every state
   assign low_speed_o = sby_q[SMC_CLKSEL_BIT];
   assign hold_ack_o = st_q == SMC_HOLD;
   assign bus_oe_o = !(st_q == SMC_HOLD);
   assign port_oe_o = !(st_q == SMC_STOP && sby_q[SMC_FLOAT_BIT]) &&
      !(st_q == SMC_HOLD && pcfg_q[SMC_BUS_SF_BIT]);

   genvar g;
   generate
      for (g = 0; g < SMC_PER_N; g++) begin : g_per
         if (g == SMC_PER_WDOG) begin : g_wd
            assign per_run_o[g] = st_q != SMC_STOP && st_q != SMC_HOLD;
         end else if (g == SMC_PER_SER3) begin : g_s3
            assign per_run_o[g] = st_q != SMC_STOP || pcfg_q[SMC_SER3_SLAVE_BIT];
         end else if (g == SMC_PER_RTC) begin : g_rtc
            assign per_run_o[g] = 1'b1;
         end else begin : g_gen
            assign per_run_o[g] = st_q != SMC_STOP;
         end
      end
   endgenerate

   // serial data pin in float stop
   assign p10_sdo_o = ser3_data_i;
   assign p10_sdo_oe_o = !(st_q == SMC_STOP && sby_q[SMC_FLOAT_BIT] &&
      pcfg_q[SMC_SCLK_SF_BIT]);

   // Stop request as the port presents it, before the latch is judged
   sequence s_stop_req;
      wr_sby && reg_wdata_i[SMC_STOP_BIT] && st_q == SMC_RUN;
   endsequence

   // Hold request gone while the bus is lent out
   sequence s_hold_drop;
      ce_i && st_q == SMC_HOLD && !hold_lvl;
   endsequence

   // Same-clock sources; the pin source lags by its synchroniser
   sequence s_src_fire;
      ce_i && (break_instruction_i || opcode_trap_i || watchdog_overflow_i);
   endsequence

   // Stop entry and exit
   a_stop_locked: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (s_stop_req and (ce_i && !armed && !sys_rst_q)) |=> st_q != SMC_STOP)
      else $error("stop entered without unlock");
   a_stop_enter: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (s_stop_req and (ce_i && armed && !sys_rst_q)) |=> st_q == SMC_STOP && !per_clk_en_o)
      else $error("stop not entered when armed");
   a_stop_exit: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ce_i && st_q == SMC_STOP && irq_i |=>
      st_q == SMC_RUN && !sby_q[SMC_STOP_BIT] && per_clk_en_o)
      else $error("stop not released");
   a_quick_osc: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      st_q == SMC_STOP |-> osc_run_o == !sby_q[SMC_OSCS_BIT])
      else $error("oscillator state wrong in stop");
   a_port_float: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      st_q == SMC_STOP |-> port_oe_o == !sby_q[SMC_FLOAT_BIT])
      else $error("output pins float wrong in stop");

   // Hold handshake
   a_bus_release: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      st_q == SMC_HOLD |-> port_oe_o == !pcfg_q[SMC_BUS_SF_BIT])
      else $error("bus pins not released in hold");
   a_hold_enter: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ce_i && st_q == SMC_RUN && hold_lvl && prph_q[SMC_HOLDEN_BIT] && !stop_go
      && !sys_rst_q |=> hold_ack_o && !bus_oe_o)
      else $error("hold not entered");
   a_hold_noen: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      st_q == SMC_HOLD |-> prph_q[SMC_HOLDEN_BIT] || $past(prph_q[SMC_HOLDEN_BIT]))
      else $error("hold without enable");
   a_hold_exit: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      s_hold_drop |=> st_q == SMC_RUN && bus_oe_o && !hold_ack_o)
      else $error("hold not released");

   // Halt
   a_halt_cpu: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      st_q == SMC_HALT |-> !cpu_clk_en_o && per_clk_en_o)
      else $error("halt clocks wrong");
   a_halt_exit: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      ce_i && st_q == SMC_HALT && irq_i |=> st_q == SMC_RUN && !sby_q[SMC_HALT_BIT])
      else $error("halt not released");

   // Peripheral run enables and the serial data pin
   a_wdog_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      st_q == SMC_HOLD |-> !per_run_o[SMC_PER_WDOG] && per_run_o[SMC_PER_TIMEBASE])
      else $error("watchdog runs in hold");
   a_stop_run: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      st_q == SMC_STOP |-> per_run_o[SMC_PER_SER3] == pcfg_q[SMC_SER3_SLAVE_BIT] &&
      per_run_o[SMC_PER_RTC] && !per_run_o[SMC_PER_TIMEBASE])
      else $error("peripheral run wrong in stop");
   a_sdo_float: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      st_q == SMC_STOP && sby_q[SMC_FLOAT_BIT] |->
      p10_sdo_oe_o == !pcfg_q[SMC_SCLK_SF_BIT])
      else $error("serial data pin float wrong");
   a_sdo_drive: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      st_q == SMC_STOP && sby_q[SMC_FLOAT_BIT] && !pcfg_q[SMC_SCLK_SF_BIT] |->
      p10_sdo_oe_o && p10_sdo_o == ser3_data_i)
      else $error("serial data pin not driven");

   // Reset sources: flag next cycle, registers restored the cycle after
   a_src_reset: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      s_src_fire |=> sys_reset_o)
      else $error("reset source not flagged");
   a_src_restore: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      (s_src_fire ##1 ce_i) |=> st_q == SMC_RUN && sby_q == SMC_SBYCTL_RST)
      else $error("reset source did not restore state");
endmodule

// ==== testbench/smc_hold_master.sv ====
// Model of the external bus master that borrows the bus through hold
`timescale 1ns/1ps
module smc_hold_master (
   input wire logic core_clk_i,
   input wire logic req_i,
   input wire logic hold_ack_i,
   input wire logic bus_oe_i,
   output logic hold_o,
   output logic drive_o,
   output logic clash_o
);
   initial hold_o = 1'b0;
   always @(posedge core_clk_i) begin
      hold_o <= req_i;
   end
   assign drive_o = hold_o & hold_ack_i;
   // Two drivers at once would corrupt the shared bus
   assign clash_o = drive_o & bus_oe_i;
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the standby mode controller
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
   $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module tb;
   import smc_pkg::*;
   logic core_clk_i, rst_n_i, ce_i, reg_wr_i, reg_rd_i, ext_reset_pin_n_i, hold_pin_i;
   logic break_instruction_i, opcode_trap_i, watchdog_overflow_i, irq_i, ser3_data_i;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
   logic hold_ack_o, cpu_clk_en_o, per_clk_en_o, osc_run_o, low_speed_o, sys_reset_o;
   logic bus_oe_o, port_oe_o, p10_sdo_o, p10_sdo_oe_o, hold_req, drive, clash;
   logic [SMC_PER_N-1:0] per_run_o;
   int err_total, comparisons;

   smc_top dut (.core_clk_i, .rst_n_i, .ce_i, .reg_addr_i, .reg_wdata_i,
      .reg_wr_i, .reg_rd_i, .reg_rdata_o, .ext_reset_pin_n_i, .hold_pin_i,
      .break_instruction_i, .opcode_trap_i, .watchdog_overflow_i, .irq_i, .hold_ack_o,
      .cpu_clk_en_o, .per_clk_en_o, .per_run_o, .osc_run_o, .low_speed_o, .sys_reset_o,
      .bus_oe_o, .port_oe_o, .ser3_data_i, .p10_sdo_o, .p10_sdo_oe_o);
   smc_hold_master master (.core_clk_i, .req_i(hold_req), .hold_ack_i(hold_ack_o),
      .bus_oe_i(bus_oe_o), .hold_o(hold_pin_i), .drive_o(drive), .clash_o(clash));

   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end

   always @(posedge core_clk_i) begin
      if (clash === 1'b1) begin
         err_total++;
         $display("unexpected at %0t: bus driven from both sides", $time);
      end
   end

   task automatic close_out();
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      d = reg_rdata_o;
      `CHK(d, e)
   endtask

   // Polls the mode field of the status register, bounded
   task automatic wait_mode(input logic [3:0] st);
      for (int i = 0; i < 20; i++) begin
         @(posedge core_clk_i);
         reg_addr_i <= SMC_ADDR_STATUS;
         reg_rd_i <= 1'b1;
         @(posedge core_clk_i);
         reg_rd_i <= 1'b0;
         #1;
         if (reg_rdata_o[3:0] === st) begin
            comparisons++;
            return;
         end
      end
      err_total++;
      $display("unexpected at %0t: mode %h never reached", $time, st);
      close_out();
   endtask

   task automatic irq_exit();
      @(posedge core_clk_i);
      irq_i <= 1'b1;
      wait_mode(4'h1);
      @(posedge core_clk_i);
      irq_i <= 1'b0;
   endtask

   task automatic t_reset();
      step(1);
      `CHK({cpu_clk_en_o, per_clk_en_o, bus_oe_o, hold_ack_o}, 4'hE)
      chk_rd(SMC_ADDR_SBYCTL, SMC_SBYCTL_RST);
      chk_rd(SMC_ADDR_PRPHCTL, SMC_PRPHCTL_RST);
      chk_rd(SMC_ADDR_STATUS, 8'h01);
      chk_rd(8'h30, 8'h00);
   endtask

   // Halt, first with the clock enable low, when nothing may move
   task automatic t_halt();
      @(posedge core_clk_i);
      ce_i <= 1'b0;
      wr(SMC_ADDR_SBYCTL, 8'h4A);
      step(2);
      `CHK({cpu_clk_en_o, low_speed_o}, 2'b10)
      @(posedge core_clk_i);
      ce_i <= 1'b1;
      chk_rd(SMC_ADDR_SBYCTL, SMC_SBYCTL_RST);
      wr(SMC_ADDR_SBYCTL, 8'h4A);
      step(2);
      `CHK({cpu_clk_en_o, per_clk_en_o, low_speed_o}, 3'b011)
      `CHK(per_run_o, 10'h3FF)
      irq_exit();
      chk_rd(SMC_ADDR_SBYCTL, 8'h48);
      wr(SMC_ADDR_SBYCTL, 8'h08);
   endtask

   // A broken unlock pair must leave the stop bit without effect
   task automatic t_refuse();
      wr(SMC_ADDR_UNLOCK, 8'h05);
      wr(SMC_ADDR_UNLOCK, 8'h00);
      wr(SMC_ADDR_UNLOCK, 8'h0A);
      wr(SMC_ADDR_SBYCTL, 8'h09);
      step(2);
      `CHK(per_clk_en_o, 1'b1)
      chk_rd(SMC_ADDR_SBYCTL, 8'h08);
      chk_rd(SMC_ADDR_STATUS, 8'h01);
   endtask

   task automatic t_stop(input logic [7:0] ctl, input logic [7:0] pin,
      input logic [3:0] e_pins, input logic [9:0] e_run);
      wr(SMC_ADDR_PINCFG, pin);
      wr(SMC_ADDR_UNLOCK, 8'h35);
      wr(SMC_ADDR_UNLOCK, 8'hFA);
      chk_rd(SMC_ADDR_STATUS, 8'h11);
      wr(SMC_ADDR_SBYCTL, ctl);
      step(2);
      `CHK({cpu_clk_en_o, per_clk_en_o}, 2'b00)
      `CHK({osc_run_o, port_oe_o, p10_sdo_oe_o, p10_sdo_o}, e_pins)
      `CHK(per_run_o, e_run)
      chk_rd(SMC_ADDR_STATUS, 8'h08);
      irq_exit();
      chk_rd(SMC_ADDR_SBYCTL, ctl & 8'hFE);
   endtask

   task automatic t_hold();
      wr(SMC_ADDR_PINCFG, 8'h04);
      @(posedge core_clk_i);
      hold_req <= 1'b1;
      step(12);
      `CHK({hold_ack_o, bus_oe_o}, 2'b01)
      wr(SMC_ADDR_PRPHCTL, 8'hAC);
      wait_mode(4'h4);
      `CHK({hold_ack_o, bus_oe_o, port_oe_o, cpu_clk_en_o, drive}, 5'h11)
      `CHK(per_run_o, 10'h37F)
      @(posedge core_clk_i);
      hold_req <= 1'b0;
      wait_mode(4'h1);
      `CHK({hold_ack_o, bus_oe_o, port_oe_o}, 3'b011)
   endtask

   // Every reset source, each fired while halted
   task automatic t_src();
      for (int k = 0; k < 4; k++) begin
         wr(SMC_ADDR_SBYCTL, 8'h4A);
         @(posedge core_clk_i);
         case (k)
            0: ext_reset_pin_n_i <= 1'b0;
            1: break_instruction_i <= 1'b1;
            2: opcode_trap_i <= 1'b1;
            default: watchdog_overflow_i <= 1'b1;
         endcase
         @(posedge core_clk_i);
         {break_instruction_i, opcode_trap_i, watchdog_overflow_i} <= 3'b000;
         #1;
         for (int n = 0; n < 10 && sys_reset_o !== 1'b1; n++) step(1);
         `CHK(sys_reset_o, 1'b1)
         @(posedge core_clk_i);
         ext_reset_pin_n_i <= 1'b1;
         step(10);
         chk_rd(SMC_ADDR_SBYCTL, SMC_SBYCTL_RST);
         chk_rd(SMC_ADDR_STATUS, 8'h01);
      end
   endtask

   initial begin
      err_total = 0;
      comparisons = 0;
      rst_n_i = 1'b0;
      ce_i = 1'b1;
      {reg_wr_i, reg_rd_i, hold_req, irq_i} = 4'h0;
      {break_instruction_i, opcode_trap_i, watchdog_overflow_i} = 3'b000;
      ext_reset_pin_n_i = 1'b1;
      ser3_data_i = 1'b1;
      reg_addr_i = 8'h00;
      reg_wdata_i = 8'h00;
      repeat (10) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_halt();
      t_refuse();
      t_stop(8'h0D, 8'h01, 4'b0001, 10'h200);
      t_stop(8'h05, 8'h02, 4'b1011, 10'h300);
      @(posedge core_clk_i);
      ser3_data_i <= 1'b0;
      t_stop(8'h01, 8'h00, 4'b1110, 10'h200);
      t_hold();
      t_src();
      close_out();
   end
endmodule
